// ===== rtl/bdm_pkg.sv
// bdm_pkg: constants, types and shared decode for the banked data memory addressing block
package bdm_pkg;

  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 8;
  localparam int BANK_W     = 4;
  localparam int OFFS_W     = 8;
  localparam int BANK_COUNT = 16;
  localparam int BANK_SIZE  = 256;
  localparam int IMPL_BANKS = 2;
  localparam int SPECIAL_SIZE  = 128;
  localparam int SPECIAL_IDX_W = 7;

  typedef logic [ADDR_W-1:0] bdm_addr_type;
  typedef logic [DATA_W-1:0] bdm_data_type;
  typedef logic [BANK_W-1:0] bdm_bank_type;
  typedef logic [OFFS_W-1:0] bdm_offs_type;

  // bank select register: only the low nibble exists
  localparam bdm_data_type BANK_SEL_MASK  = 8'h0F;
  localparam bdm_bank_type BANK_SEL_RESET = 4'h0;
  localparam bdm_bank_type BANK_SEL_PAD   = 4'h0;

  // fixed locations in the data space
  localparam bdm_addr_type BANK_SEL_ADDR = 12'hFE0;
  localparam bdm_addr_type PCL_FULL_ADDR = 12'hFF9;
  localparam bdm_addr_type SPECIAL_BASE  = 12'hF80;
  localparam bdm_addr_type SPECIAL_TOP   = 12'hFFF;

  // access bank layout
  localparam bdm_bank_type ACCESS_LOW_BANK  = 4'h0;
  localparam bdm_bank_type ACCESS_HIGH_BANK = 4'hF;
  localparam bdm_offs_type ACCESS_SPLIT     = 8'h80;
  localparam bdm_offs_type EXT_ACCESS_SPLIT = 8'h60;

  localparam bdm_data_type READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    BDM_MAP_BANKED  = 2'b00,
    BDM_MAP_ACCESS  = 2'b01,
    BDM_MAP_INDEXED = 2'b10,
    BDM_MAP_FULL    = 2'b11
  } bdm_map_type;

  // true for locations backed by storage (general bank 0 and the special register half)
  function automatic logic is_implemented(input bdm_addr_type a);
    is_implemented = (a[ADDR_W-1 -: BANK_W] == ACCESS_LOW_BANK) || (a >= SPECIAL_BASE);
  endfunction : is_implemented

endpackage : bdm_pkg

// ===== rtl/bdm_mem_if.sv
// bdm_mem_if: read and write port between the address core and the data store
`timescale 1ns/10ps
`default_nettype none
interface bdm_mem_if;
  bdm_pkg::bdm_addr_type rd_addr;
  bdm_pkg::bdm_data_type rd_data;
  logic                  rd_hit;
  bdm_pkg::bdm_addr_type wr_addr;
  bdm_pkg::bdm_data_type wr_data;
  logic                  wr_en;

  modport core  (output rd_addr, input rd_data, input rd_hit,
                 output wr_addr, output wr_data, output wr_en);
  modport store (input rd_addr, output rd_data, output rd_hit,
                 input wr_addr, input wr_data, input wr_en);
endinterface : bdm_mem_if
`default_nettype wire

// ===== rtl/bdm_addr_gen.sv
// bdm_addr_gen: combinational effective address from access bit, bank select and operand
`timescale 1ns/10ps
`default_nettype none
module bdm_addr_gen (
  input  wire logic                  access_bit,
  input  wire bdm_pkg::bdm_bank_type bank_sel,
  input  wire bdm_pkg::bdm_offs_type offset,
  input  wire logic                  ext_enable,
  input  wire bdm_pkg::bdm_addr_type index_base,
  output bdm_pkg::bdm_addr_type      eff_addr,
  output bdm_pkg::bdm_map_type       map_kind
);

  // purely combinational so operand read and destination write share one cycle
  always_comb begin
    if (access_bit) begin
      eff_addr = {bank_sel, offset};
      map_kind = bdm_pkg::BDM_MAP_BANKED;
    end else if (ext_enable && (offset < bdm_pkg::EXT_ACCESS_SPLIT)) begin
      // extended mapping: low offsets index from the pointer base
      eff_addr = bdm_pkg::ADDR_W'(index_base + bdm_pkg::ADDR_W'(offset));
      map_kind = bdm_pkg::BDM_MAP_INDEXED;
    end else if (offset < bdm_pkg::ACCESS_SPLIT) begin
      eff_addr = {bdm_pkg::ACCESS_LOW_BANK, offset};
      map_kind = bdm_pkg::BDM_MAP_ACCESS;
    end else begin
      eff_addr = {bdm_pkg::ACCESS_HIGH_BANK, offset};
      map_kind = bdm_pkg::BDM_MAP_ACCESS;
    end
  end

endmodule : bdm_addr_gen
`default_nettype wire

// ===== rtl/bdm_data_store.sv
// bdm_data_store: general purpose bank 0 and the special register half of bank 15
`timescale 1ns/10ps
`default_nettype none
module bdm_data_store #(
  parameter int GENERAL_DEPTH = bdm_pkg::BANK_SIZE,
  parameter int SPECIAL_DEPTH = bdm_pkg::SPECIAL_SIZE
) (
  input  wire logic clk,
  bdm_mem_if.store  mem
);

  // no reset on either array: contents survive every reset
  bdm_pkg::bdm_data_type general_mem [GENERAL_DEPTH];
  bdm_pkg::bdm_data_type special_mem [SPECIAL_DEPTH];

  logic rd_special;
  logic wr_special;
  logic wr_ok;

  always_comb begin
    rd_special  = mem.rd_addr >= bdm_pkg::SPECIAL_BASE;
    wr_special  = mem.wr_addr >= bdm_pkg::SPECIAL_BASE;
    wr_ok       = mem.wr_en && bdm_pkg::is_implemented(mem.wr_addr);
    mem.rd_hit  = bdm_pkg::is_implemented(mem.rd_addr);
    if (!mem.rd_hit) begin
      mem.rd_data = bdm_pkg::READ_ZERO;
    end else if (rd_special) begin
      mem.rd_data = special_mem[mem.rd_addr[bdm_pkg::SPECIAL_IDX_W-1:0]];
    end else begin
      mem.rd_data = general_mem[mem.rd_addr[bdm_pkg::OFFS_W-1:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (wr_ok && wr_special) begin
      special_mem[mem.wr_addr[bdm_pkg::SPECIAL_IDX_W-1:0]] <= mem.wr_data;
    end
    if (wr_ok && !wr_special) begin
      general_mem[mem.wr_addr[bdm_pkg::OFFS_W-1:0]] <= mem.wr_data;
    end
  end

endmodule : bdm_data_store
`default_nettype wire

// ===== rtl/bdm_core.sv
// bdm_core: bank select register, operand address resolution and data memory access
// Function
// - every data location has a 12-bit address, 4096 bytes of space.
// - sixteen banks of 256 bytes; only two are physically implemented.
// - reads of unimplemented locations return zero.
// - banked address is bank select nibble above the 8-bit operand.
// - bank select keeps low four bits; upper four read zero, ignore writes.
// - load-bank-literal instruction loads bank select directly from literal.
// - writes to unimplemented banks dropped; reads from them return zero.
// - status flags still update as if unimplemented access succeeded.
// - full-address move uses 12-bit source and destination, ignores bank select.
// - other instructions resolve operand via bank select or access map.
// - access offsets 00-7F hit bank 0 bottom, 80-FF bank 15 top.
// - access bit one: address from bank select plus operand.
// - access bit zero: access map used, bank select ignored.
// - access bank operand completes in one cycle, no bank select update.
// - extended set enabled: modified access bank mapping applies.
// - bank select 0F with banked write to F9 reaches program counter low.
// - special registers occupy F80 through FFF, top half of bank 15.
// - general purpose RAM uninitialised at power-on, untouched by resets.
`timescale 1ns/10ps
`default_nettype none
module bdm_core #(
  parameter int GENERAL_DEPTH = bdm_pkg::BANK_SIZE,
  parameter int SPECIAL_DEPTH = bdm_pkg::SPECIAL_SIZE
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  SRST,
  input  wire logic                  OP_VALID,
  input  wire logic                  OP_ACCESS_BIT,
  input  wire bdm_pkg::bdm_offs_type OP_OFFSET,
  input  wire logic                  OP_READ,
  input  wire logic                  OP_WRITE,
  input  wire bdm_pkg::bdm_data_type OP_WDATA,
  input  wire logic                  MOVE_FULL_ADDRESS,
  input  wire bdm_pkg::bdm_addr_type MOVE_SRC_ADDR,
  input  wire bdm_pkg::bdm_addr_type MOVE_DST_ADDR,
  input  wire logic                  LOAD_BANK_LITERAL,
  input  wire bdm_pkg::bdm_data_type BANK_LITERAL,
  input  wire logic                  EXTENDED_SET_ENABLE,
  input  wire bdm_pkg::bdm_addr_type INDEX_BASE,
  output logic                       RD_VALID,
  output bdm_pkg::bdm_data_type      RD_DATA,
  output logic                       OP_DONE,
  output logic                       OP_UNIMPL,
  output bdm_pkg::bdm_addr_type      EFF_ADDR,
  output bdm_pkg::bdm_data_type      BANK_SELECT_REG,
  output logic                       PCL_WRITE,
  output bdm_pkg::bdm_data_type      PCL_DATA
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  bdm_mem_if mem ();

  bdm_pkg::bdm_bank_type bank_sel_q,  bank_sel_d;
  logic                  rd_valid_q,  rd_valid_d;
  bdm_pkg::bdm_data_type rd_data_q,   rd_data_d;
  logic                  op_done_q,   op_done_d;
  logic                  op_unimpl_q, op_unimpl_d;
  bdm_pkg::bdm_addr_type eff_addr_q,  eff_addr_d;
  logic                  pcl_write_q, pcl_write_d;
  bdm_pkg::bdm_data_type pcl_data_q,  pcl_data_d;

  bdm_pkg::bdm_addr_type op_addr;
  bdm_pkg::bdm_addr_type src_addr;
  bdm_pkg::bdm_addr_type dst_addr;
  bdm_pkg::bdm_data_type src_data;
  bdm_pkg::bdm_data_type dst_data;
  logic                  do_read;
  logic                  do_write;
  logic                  src_is_bank_sel;
  logic                  dst_is_bank_sel;
  logic                  src_known;
  logic                  dst_known;

  ////////////////////////////////////////////////////////////////////////////////
  // operand address and storage

  // bank select is handed in even when the access map will win; the generator drops it
  bdm_addr_gen u_addr_gen (
    .access_bit (OP_ACCESS_BIT),
    .bank_sel   (bank_sel_q),
    .offset     (OP_OFFSET),
    .ext_enable (EXTENDED_SET_ENABLE),
    .index_base (INDEX_BASE),
    .eff_addr   (op_addr),
    .map_kind   ()
  );

  bdm_data_store #(
    .GENERAL_DEPTH (GENERAL_DEPTH),
    .SPECIAL_DEPTH (SPECIAL_DEPTH)
  ) u_store (
    .clk (CLK_SYS),
    .mem (mem)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // source and destination selection

  always_comb begin
    if (MOVE_FULL_ADDRESS) begin
      // full move names both ends outright; bank select plays no part
      src_addr = MOVE_SRC_ADDR;
      dst_addr = MOVE_DST_ADDR;
      do_read  = OP_VALID;
      do_write = OP_VALID;
    end else begin
      // single operand: same resolved address for read and write
      src_addr = op_addr;
      dst_addr = op_addr;
      do_read  = OP_VALID && OP_READ;
      do_write = OP_VALID && OP_WRITE;
    end
    src_is_bank_sel = src_addr == bdm_pkg::BANK_SEL_ADDR;
    dst_is_bank_sel = dst_addr == bdm_pkg::BANK_SEL_ADDR;
  end

  // the bank select register sits in the special area but is held here, not in the array
  always_comb begin
    if (src_is_bank_sel) begin
      src_data  = {bdm_pkg::BANK_SEL_PAD, bank_sel_q};
      src_known = 1'b1;
    end else begin
      src_data  = mem.rd_data;
      src_known = mem.rd_hit;
    end
    dst_data  = MOVE_FULL_ADDRESS ? src_data : OP_WDATA;
    dst_known = dst_is_bank_sel || bdm_pkg::is_implemented(dst_addr);
  end

  always_comb begin
    mem.rd_addr = src_addr;
    mem.wr_addr = dst_addr;
    mem.wr_data = dst_data;
    // store drops writes outside implemented space on its own
    mem.wr_en   = do_write && !dst_is_bank_sel;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bank select register

  always_comb begin
    bank_sel_d = bank_sel_q;
    if (LOAD_BANK_LITERAL) begin
      // only the low nibble of the literal is kept
      bank_sel_d = bdm_pkg::bdm_bank_type'(BANK_LITERAL & bdm_pkg::BANK_SEL_MASK);
    end else if (do_write && dst_is_bank_sel) begin
      bank_sel_d = bdm_pkg::bdm_bank_type'(dst_data & bdm_pkg::BANK_SEL_MASK);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      bank_sel_q <= bdm_pkg::BANK_SEL_RESET;
    end else begin
      bank_sel_q <= bank_sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // answer to the execute pipeline

  always_comb begin
    rd_valid_d  = do_read;
    rd_data_d   = do_read ? src_data : bdm_pkg::READ_ZERO;
    // completion is reported whether or not storage exists, so flags update as usual
    op_done_d   = OP_VALID;
    op_unimpl_d = OP_VALID && ((do_read && !src_known) || (do_write && !dst_known));
    eff_addr_d  = OP_VALID ? dst_addr : eff_addr_q;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rd_valid_q  <= 1'b0;
      rd_data_q   <= bdm_pkg::READ_ZERO;
      op_done_q   <= 1'b0;
      op_unimpl_q <= 1'b0;
      eff_addr_q  <= '0;
    end else begin
      rd_valid_q  <= rd_valid_d;
      rd_data_q   <= rd_data_d;
      op_done_q   <= op_done_d;
      op_unimpl_q <= op_unimpl_d;
      eff_addr_q  <= eff_addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // program counter low byte

  // any write that lands on the counter low byte redirects flow, including a
  // banked write at offset F9 with bank 0F; a stray bank setting makes this easy to hit
  always_comb begin
    pcl_write_d = do_write && (dst_addr == bdm_pkg::PCL_FULL_ADDR);
    pcl_data_d  = pcl_write_d ? dst_data : pcl_data_q;
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pcl_write_q <= 1'b0;
      pcl_data_q  <= bdm_pkg::READ_ZERO;
    end else begin
      pcl_write_q <= pcl_write_d;
      pcl_data_q  <= pcl_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    RD_VALID        = rd_valid_q;
    RD_DATA         = rd_data_q;
    OP_DONE         = op_done_q;
    OP_UNIMPL       = op_unimpl_q;
    EFF_ADDR        = eff_addr_q;
    BANK_SELECT_REG = {bdm_pkg::BANK_SEL_PAD, bank_sel_q};
    PCL_WRITE       = pcl_write_q;
    PCL_DATA        = pcl_data_q;
  end

endmodule : bdm_core
`default_nettype wire

// ===== tb/bdm_cpu_model.sv
// bdm_cpu_model: decode side that issues operand, full move and bank load requests
`timescale 1ns/10ps
`default_nettype none
module bdm_cpu_model (
  input wire logic CLK_SYS,
  output logic OP_VALID,
  output logic OP_ACCESS_BIT,
  output bdm_pkg::bdm_offs_type OP_OFFSET,
  output logic OP_READ,
  output logic OP_WRITE,
  output bdm_pkg::bdm_data_type OP_WDATA,
  output logic MOVE_FULL_ADDRESS,
  output bdm_pkg::bdm_addr_type MOVE_SRC_ADDR,
  output bdm_pkg::bdm_addr_type MOVE_DST_ADDR,
  output logic LOAD_BANK_LITERAL,
  output bdm_pkg::bdm_data_type BANK_LITERAL,
  output logic EXTENDED_SET_ENABLE,
  output bdm_pkg::bdm_addr_type INDEX_BASE
);
  initial begin
    {OP_VALID, OP_ACCESS_BIT, OP_READ, OP_WRITE, MOVE_FULL_ADDRESS} = 5'h00;
    {LOAD_BANK_LITERAL, EXTENDED_SET_ENABLE} = 2'h0;
    {OP_OFFSET, OP_WDATA, BANK_LITERAL} = 24'h00_0000;
    {MOVE_SRC_ADDR, MOVE_DST_ADDR, INDEX_BASE} = 36'h0_0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // released operands show inverted values so stale data is never mistaken for valid
  task automatic op(input logic acc, input bdm_pkg::bdm_offs_type off, input logic rd,
                    input logic wr, input bdm_pkg::bdm_data_type wd);
    @(negedge CLK_SYS);
    {OP_VALID, OP_ACCESS_BIT, OP_READ, OP_WRITE} = {1'b1, acc, rd, wr};
    OP_OFFSET = off;
    OP_WDATA = wd;
    @(negedge CLK_SYS);
    {OP_VALID, OP_READ, OP_WRITE} = 3'h0;
    OP_OFFSET = ~off;
    OP_WDATA = ~wd;
  endtask : op
  task automatic move(input bdm_pkg::bdm_addr_type src, input bdm_pkg::bdm_addr_type dst);
    @(negedge CLK_SYS);
    {OP_VALID, MOVE_FULL_ADDRESS} = 2'h3;
    MOVE_SRC_ADDR = src;
    MOVE_DST_ADDR = dst;
    @(negedge CLK_SYS);
    {OP_VALID, MOVE_FULL_ADDRESS} = 2'h0;
    MOVE_SRC_ADDR = ~src;
    MOVE_DST_ADDR = ~dst;
  endtask : move
  task automatic load(input bdm_pkg::bdm_data_type lit);
    @(negedge CLK_SYS);
    LOAD_BANK_LITERAL = 1'b1;
    BANK_LITERAL = lit;
    @(negedge CLK_SYS);
    LOAD_BANK_LITERAL = 1'b0;
    BANK_LITERAL = ~lit;
  endtask : load
  task automatic cfg(input logic ext, input bdm_pkg::bdm_addr_type base);
    @(negedge CLK_SYS);
    EXTENDED_SET_ENABLE = ext;
    INDEX_BASE = base;
  endtask : cfg
endmodule : bdm_cpu_model
`default_nettype wire

// ===== tb/bdm_core_checker.sv
// bdm_core_checker: port-level assertions for the addressing core
`timescale 1ns/10ps
`default_nettype none
module bdm_core_checker (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic OP_VALID,
  input wire logic OP_ACCESS_BIT,
  input wire bdm_pkg::bdm_offs_type OP_OFFSET,
  input wire logic OP_READ,
  input wire logic OP_WRITE,
  input wire bdm_pkg::bdm_data_type OP_WDATA,
  input wire logic MOVE_FULL_ADDRESS,
  input wire bdm_pkg::bdm_addr_type MOVE_DST_ADDR,
  input wire logic LOAD_BANK_LITERAL,
  input wire bdm_pkg::bdm_data_type BANK_LITERAL,
  input wire logic EXTENDED_SET_ENABLE,
  input wire bdm_pkg::bdm_data_type RD_DATA,
  input wire logic OP_DONE,
  input wire bdm_pkg::bdm_addr_type EFF_ADDR,
  input wire bdm_pkg::bdm_data_type BANK_SELECT_REG,
  input wire logic PCL_WRITE,
  input wire bdm_pkg::bdm_data_type PCL_DATA
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////////////////////
  a_done_after_op: assert property (OP_VALID |=> OP_DONE)
    else $error("no completion after request");
  a_no_stray_done: assert property (!OP_VALID && !LOAD_BANK_LITERAL |=> !OP_DONE)
    else $error("completion without request");
  a_bank_upper_zero: assert property (BANK_SELECT_REG[7:4] == 4'h0)
    else $error("bank select upper nibble set");
  a_bank_literal_load: assert property (LOAD_BANK_LITERAL |=>
    BANK_SELECT_REG == {4'h0, $past(BANK_LITERAL[3:0])}) else $error("bank load wrong");
  a_banked_address: assert property (OP_VALID && OP_ACCESS_BIT && !MOVE_FULL_ADDRESS |=>
    EFF_ADDR == {$past(BANK_SELECT_REG[3:0]), $past(OP_OFFSET)}) else $error("banked addr");
  a_access_map: assert property (OP_VALID && !OP_ACCESS_BIT && !MOVE_FULL_ADDRESS &&
    !EXTENDED_SET_ENABLE |=> EFF_ADDR == {{4{$past(OP_OFFSET[7])}}, $past(OP_OFFSET)})
    else $error("access bank addr");
  a_full_move_dst: assert property (OP_VALID && MOVE_FULL_ADDRESS |=>
    EFF_ADDR == $past(MOVE_DST_ADDR)) else $error("full move addr");
  a_counter_write: assert property (OP_VALID && OP_WRITE && OP_ACCESS_BIT &&
    !MOVE_FULL_ADDRESS && BANK_SELECT_REG == 8'h0F && OP_OFFSET == 8'hF9 |=>
    PCL_WRITE && PCL_DATA == $past(OP_WDATA)) else $error("counter write missed");
  a_unimpl_read_zero: assert property (OP_VALID && OP_READ && OP_ACCESS_BIT &&
    !MOVE_FULL_ADDRESS && BANK_SELECT_REG[3:0] inside {[4'h1:4'hE]} |=> RD_DATA == 8'h00)
    else $error("unimplemented bank read nonzero");
endmodule : bdm_core_checker
bind bdm_core bdm_core_checker u_checker (.*);
`default_nettype wire

// ===== tb/tb_banked_data_memory_addressing.sv
// tb_banked_data_memory_addressing: directed scenarios for the addressing core
`timescale 1ns/10ps
`default_nettype none
module tb_banked_data_memory_addressing;
  logic CLK_SYS, SRST, OP_VALID, OP_ACCESS_BIT, OP_READ, OP_WRITE, MOVE_FULL_ADDRESS;
  logic LOAD_BANK_LITERAL, EXTENDED_SET_ENABLE, RD_VALID, OP_DONE, OP_UNIMPL, PCL_WRITE;
  bdm_pkg::bdm_offs_type OP_OFFSET;
  bdm_pkg::bdm_data_type OP_WDATA, BANK_LITERAL, RD_DATA, BANK_SELECT_REG, PCL_DATA;
  bdm_pkg::bdm_addr_type MOVE_SRC_ADDR, MOVE_DST_ADDR, INDEX_BASE, EFF_ADDR;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  bdm_core DUT (.*);
  bdm_cpu_model cpu (.*);
  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  // every bank: upper literal bits dropped, only bank 0 keeps the byte
  task automatic t_banks;
    for (int b = 0; b < 16; b++) begin
      cpu.load(8'hF0 | 8'(b));
      check(BANK_SELECT_REG, 12'(b));
      cpu.op(1'b1, 8'h40, 1'b0, 1'b1, 8'(b + 1));
      check(OP_DONE, 1'b1);
      check(OP_UNIMPL, b != 0);
      check(EFF_ADDR, {b[3:0], 8'h40});
      cpu.op(1'b1, 8'h40, 1'b1, 1'b0, 8'h00);
      check(RD_VALID, 1'b1);
      check(RD_DATA, (b == 0) ? 12'h001 : 12'h000);
    end
  endtask : t_banks
  task automatic t_access;
    cpu.op(1'b0, 8'h10, 1'b0, 1'b1, 8'h5A);
    check(EFF_ADDR, 12'h010);
    cpu.op(1'b0, 8'h85, 1'b0, 1'b1, 8'hC3);
    check(EFF_ADDR, 12'hF85);
    cpu.load(8'h00);
    cpu.op(1'b1, 8'h10, 1'b1, 1'b0, 8'h00);
    check(RD_DATA, 12'h05A);
    cpu.op(1'b0, 8'h85, 1'b1, 1'b0, 8'h00);
    check(RD_DATA, 12'h0C3);
    cpu.op(1'b0, 8'h40, 1'b1, 1'b0, 8'h00);
    check(RD_DATA, 12'h001);
  endtask : t_access
  task automatic t_move;
    cpu.load(8'h03);
    cpu.move(12'h010, 12'hF90);
    check(EFF_ADDR, 12'hF90);
    check(RD_DATA, 12'h05A);
    check(OP_UNIMPL, 1'b0);
    cpu.op(1'b0, 8'h90, 1'b1, 1'b0, 8'h00);
    check(RD_DATA, 12'h05A);
    cpu.move(12'h300, 12'h020);
    check(OP_UNIMPL, 1'b1);
    cpu.op(1'b0, 8'h20, 1'b1, 1'b0, 8'h00);
    check(RD_DATA, 12'h000);
  endtask : t_move
  task automatic t_counter;
    cpu.load(8'h0F);
    cpu.op(1'b1, 8'hF9, 1'b0, 1'b1, 8'h3C);
    check(PCL_WRITE, 1'b1);
    check(PCL_DATA, 12'h03C);
    cpu.load(8'h00);
    cpu.op(1'b1, 8'hF9, 1'b0, 1'b1, 8'h77);
    check(PCL_WRITE, 1'b0);
  endtask : t_counter
  task automatic t_ext;
    cpu.cfg(1'b1, 12'h030);
    cpu.op(1'b0, 8'h05, 1'b0, 1'b1, 8'h99);
    check(EFF_ADDR, 12'h035);
    cpu.op(1'b0, 8'h65, 1'b0, 1'b0, 8'h00);
    check(EFF_ADDR, 12'h065);
    cpu.cfg(1'b0, 12'h000);
  endtask : t_ext
  // mid-run reset clears the registers but must leave the general array alone
  task automatic t_reset;
    cpu.load(8'h05);
    @(negedge CLK_SYS);
    SRST = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    SRST = 1'b0;
    check(BANK_SELECT_REG, 12'h000);
    check(EFF_ADDR, 12'h000);
    check(PCL_DATA, 12'h000);
    cpu.op(1'b0, 8'h10, 1'b1, 1'b0, 8'h00);
    check(RD_DATA, 12'h05A);
    check(EFF_ADDR, 12'h010);
  endtask : t_reset
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    SRST = 1'b1;
    repeat (20) @(negedge CLK_SYS);
    SRST = 1'b0;
    @(negedge CLK_SYS);
    check(BANK_SELECT_REG, 12'h000);
    t_banks();
    t_access();
    t_move();
    t_counter();
    t_ext();
    t_reset();
    print_verdict();
  end
endmodule : tb_banked_data_memory_addressing
`default_nettype wire
